// ===== hdl/fhc_host_regs.sv
`timescale 1ns/1ps
// Contract
// R1: Prescaler divides oscillator by 3, 5 or 6.
// R2: 300 code, low drive type: 4 MHz.
// R3: Rate codes set filter, speed and rate.
// R4: Precomp values follow select input and rate.
// R5: Low power stops oscillator and core.
// R6: Status or data access restarts oscillator.
// R7: Request flag held off while oscillator settles.
// R8: Low power on command or after idle.
// R9: Rate and drive registers survive power down.
// R10: Unit select low only with motor enabled.
// R11: Status readable any time, no delay.
// R12: Host polls status before each non-DMA byte.
// R13: Request flag clears after each byte transfer.
// R14: Direction bit: 0 write, 1 read.
// R15: Non-DMA bit only during non-DMA execution.
// R16: Busy set first command byte, clear at end.
// R17: Seek bits set on seek, clear on sense.
// R18: Data port carries command, data, result bytes.
// R19: Motor bits drive active-low motor outputs.
// R20: DMA enable bit gates request, acknowledge, interrupt.
// R21: Core reset bit leaves registers untouched.
// R22: Full address decode, no aliasing.
// R23: DMA disabled floats interrupt and request.
// R24: Hardware reset clears drive, rate to 250.
// R25: Address map 010, 100, 101, 111.
module fhc_host_regs
  import fhc_pkg::*;
#(
  parameter int IDLE_CYCLES = FHC_IDLE_CYCLES,
  parameter int WAKE_CYCLES = FHC_WAKE_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Processor bus.
  input wire logic [2:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic [7:0] rdata_oe_out,
  // Core side.
  input wire logic [7:0] core_rdata_in,
  input wire logic core_req_in,
  input wire logic core_dir_in,
  input wire logic core_non_dma_in,
  input wire logic core_busy_in,
  input wire logic [3:0] core_seeking_in,
  input wire logic core_irq_in,
  input wire logic core_dreq_in,
  input wire logic core_idle_in,
  input wire logic power_down_cmd_in,
  input wire logic auto_power_down_in,
  output logic [7:0] core_wdata_out,
  output logic core_wr_out,
  output logic core_rd_out,
  output logic core_dma_ack_out,
  output logic core_reset_out,
  output logic core_clk_en_out,
  output logic osc_run_out,
  // Drive side and straps.
  input wire logic drive_type_input_in,
  input wire logic precomp_select_input_in,
  input wire logic disk_changed_n_in,
  input wire logic dma_acknowledge_n_in,
  output logic [3:0] motor_on_n_out,
  output logic [3:0] unit_select_n_out,
  output logic filter_ground_fast_out,
  output logic filter_ground_slow_out,
  output logic spindle_speed_low_current_out,
  output logic [7:0] precomp_ns_out,
  output logic [2:0] prescale_div_out,
  output logic master_clk_tick_out,
  output logic irq_out,
  output logic irq_oe_out,
  output logic dma_request_out,
  output logic dma_request_oe_out
);

  // ----------------------------------------------------------------------
  // Registers and decode.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {FHC_RUN, FHC_SLEEP, FHC_WAKE} fhc_pwr_t;

  logic [7:0] dcr_q, dcr_d;
  logic [1:0] rate_q, rate_d;
  logic chg_q, chg_d;
  logic wr_dcr, wr_rate, sel_stat, sel_data, sel_chg;
  fhc_rate_cfg_t cfg;
  fhc_status_t stat;

  assign wr_dcr = wr_in && (addr_in == FHC_ADDR_DRIVE_CTRL); // [R22] [R25]
  assign wr_rate = wr_in && (addr_in == FHC_ADDR_RATE); // [R25]
  assign sel_stat = addr_in == FHC_ADDR_STATUS;
  assign sel_data = addr_in == FHC_ADDR_DATA;
  assign sel_chg = rd_in && (addr_in == FHC_ADDR_RATE);

  always_comb begin
    dcr_d = wr_dcr ? wdata_in : dcr_q; // [R9] [R21]
    rate_d = wr_rate ? wdata_in[1:0] : rate_q;
    chg_d = ~disk_changed_n_in;
  end

  // Hardware reset only; the soft core reset bit never touches these. [R24]
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dcr_q <= FHC_DCR_RESET;
      rate_q <= FHC_RATE_RESET;
      chg_q <= 1'b0;
    end else begin
      dcr_q <= dcr_d;
      rate_q <= rate_d;
      chg_q <= chg_d;
    end
  end

  fhc_rate_decode u_rate (
    .rate_in(rate_q),
    .drive_type_in(drive_type_input_in),
    .precomp_select_in(precomp_select_input_in),
    .cfg_out(cfg)
  );

  // ----------------------------------------------------------------------
  // Prescaler and power state.
  // ----------------------------------------------------------------------
  fhc_pwr_t pwr_q, pwr_d;
  logic [31:0] cnt_q, cnt_d;
  logic [2:0] pre_q, pre_d;
  logic tick_q, tick_d;
  logic host_touch;

  // Any status or data access wakes the oscillator. [R6]
  assign host_touch = (rd_in || wr_in) && (sel_stat || sel_data);

  always_comb begin
    pwr_d = pwr_q;
    cnt_d = cnt_q;
    case (pwr_q)
      FHC_RUN: begin
        if (power_down_cmd_in) begin
          pwr_d = FHC_SLEEP; // [R8]
        end else if (auto_power_down_in && core_idle_in && !host_touch) begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q == 32'(IDLE_CYCLES - 1)) begin
            pwr_d = FHC_SLEEP; // [R8]
          end
        end else begin
          cnt_d = '0;
        end
      end
      FHC_SLEEP: begin
        cnt_d = '0;
        if (host_touch) begin
          pwr_d = FHC_WAKE; // [R6]
        end
      end
      FHC_WAKE: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(WAKE_CYCLES - 1)) begin
          pwr_d = FHC_RUN;
          cnt_d = '0;
        end
      end
      default: begin
        pwr_d = FHC_RUN;
        cnt_d = '0;
      end
    endcase
    // Prescaler is frozen while the oscillator is off. [R1] [R5]
    pre_d = pre_q;
    tick_d = 1'b0;
    if (pwr_q == FHC_RUN) begin
      if (pre_q >= cfg.divisor - 3'h1) begin
        pre_d = '0;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_q <= FHC_RUN;
      cnt_q <= '0;
      pre_q <= '0;
      tick_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign osc_run_out = pwr_q != FHC_SLEEP; // [R5]
  assign core_clk_en_out = pwr_q == FHC_RUN; // [R5]
  assign master_clk_tick_out = tick_q;
  assign prescale_div_out = cfg.divisor;
  assign precomp_ns_out = cfg.precomp_ns;
  assign filter_ground_fast_out = cfg.fast_filter; // [R3]
  assign filter_ground_slow_out = cfg.slow_filter;
  assign spindle_speed_low_current_out = cfg.speed_high;
  assign core_reset_out = ~dcr_q[FHC_DCR_CORE_RUN]; // [R21]

  // ----------------------------------------------------------------------
  // Drive outputs. Software must drop motors before sleeping.
  // ----------------------------------------------------------------------
  logic dma_en;
  assign dma_en = dcr_q[FHC_DCR_DMA_EN];
  assign motor_on_n_out = ~dcr_q[FHC_DCR_MOTOR_LSB +: 4]; // [R19] [R9]

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_unit
    // Select only the addressed unit whose motor bit is set. [R10]
    assign unit_select_n_out[gi] =
      ~((dcr_q[1:0] == 2'(gi)) && dcr_q[FHC_DCR_MOTOR_LSB + gi]);
  end

  // DMA lines float and acknowledge is ignored when disabled. [R20] [R23]
  assign irq_out = core_irq_in;
  assign irq_oe_out = dma_en;
  assign dma_request_out = core_dreq_in;
  assign dma_request_oe_out = dma_en;
  assign core_dma_ack_out = dma_en && !dma_acknowledge_n_in;

  // ----------------------------------------------------------------------
  // Status and data port.
  // ----------------------------------------------------------------------
  // Request is masked during wake-up so the host waits via normal polling.
  always_comb begin
    stat.req_master = core_req_in && (pwr_q == FHC_RUN); // [R7] [R13]
    stat.dir_to_host = core_dir_in; // [R14]
    stat.non_dma_exec = core_non_dma_in; // [R15]
    stat.busy = core_busy_in; // [R16]
    stat.seeking = core_seeking_in; // [R17]
  end

  // Core owns the handshake; this block only steers bytes. [R18]
  assign core_wdata_out = wdata_in;
  assign core_wr_out = wr_in && sel_data && (pwr_q == FHC_RUN);
  assign core_rd_out = rd_in && sel_data && (pwr_q == FHC_RUN);

  // Read data is combinational so status needs no wait after a transfer. [R11]
  always_comb begin
    rdata_out = 8'h00;
    rdata_oe_out = 8'h00;
    if (rd_in && sel_stat) begin
      rdata_out = stat;
      rdata_oe_out = 8'hFF;
    end else if (rd_in && sel_data) begin
      rdata_out = core_rdata_in;
      rdata_oe_out = 8'hFF;
    end else if (sel_chg) begin
      rdata_out[FHC_CHG_BIT] = chg_q;
      rdata_oe_out[FHC_CHG_BIT] = 1'b1; // [R25]
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  property p_reset_vals;
    @(posedge clk_sys_in) $rose(rst_n_in) |-> dcr_q == FHC_DCR_RESET && rate_q == FHC_RATE_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // [R24]

  property p_unit_sel;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !unit_select_n_out[0] |-> dcr_q[1:0] == 2'h0 && dcr_q[4];
  endproperty
  a_unit_sel: assert property (p_unit_sel) else $error("unit 0 without motor"); // [R10]

  property p_motor;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_dcr |=> motor_on_n_out == ~$past(wdata_in[7:4]);
  endproperty
  a_motor: assert property (p_motor) else $error("motor outputs wrong"); // [R19]

  property p_dma_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !dma_en |-> !irq_oe_out && !dma_request_oe_out && !core_dma_ack_out;
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma lines active"); // [R23]

  property p_wake;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      pwr_q == FHC_SLEEP && host_touch |=> !stat.req_master && osc_run_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake wrong"); // [R7]

  property p_sleep_cmd;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      pwr_q == FHC_RUN && power_down_cmd_in |=> !osc_run_out;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd) else $error("no sleep"); // [R8]

  property p_alias;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_in && addr_in != FHC_ADDR_DRIVE_CTRL |=> $stable(dcr_q);
  endproperty
  a_alias: assert property (p_alias) else $error("aliased write"); // [R22]

  property p_soft_reset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      core_reset_out && !wr_rate |=> $stable(rate_q);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("rate changed"); // [R21]

endmodule

// ===== hdl/fhc_pkg.sv
package fhc_pkg;

  // ----------------------------------------------------------------------
  // Address decode on A2..A0.
  // ----------------------------------------------------------------------
  localparam logic [2:0] FHC_ADDR_DRIVE_CTRL = 3'h2;
  localparam logic [2:0] FHC_ADDR_STATUS = 3'h4;
  localparam logic [2:0] FHC_ADDR_DATA = 3'h5;
  localparam logic [2:0] FHC_ADDR_RATE = 3'h7;

  // ----------------------------------------------------------------------
  // Register reset values and field positions.
  // ----------------------------------------------------------------------
  localparam logic [7:0] FHC_DCR_RESET = 8'h00;
  localparam logic [1:0] FHC_RATE_RESET = 2'h2;
  localparam int FHC_DCR_MOTOR_LSB = 4;
  localparam int FHC_DCR_DMA_EN = 3;
  localparam int FHC_DCR_CORE_RUN = 2;
  localparam int FHC_CHG_BIT = 7;

  // ----------------------------------------------------------------------
  // Rate codes.
  // ----------------------------------------------------------------------
  localparam logic [1:0] FHC_RATE_500K = 2'h0;
  localparam logic [1:0] FHC_RATE_300K = 2'h1;
  localparam logic [1:0] FHC_RATE_250K = 2'h2;
  localparam logic [1:0] FHC_RATE_1M = 2'h3;

  // ----------------------------------------------------------------------
  // Prescaler divisors from the 24 MHz oscillator.
  // ----------------------------------------------------------------------
  localparam logic [2:0] FHC_DIV_8M = 3'h3;
  localparam logic [2:0] FHC_DIV_4M8 = 3'h5;
  localparam logic [2:0] FHC_DIV_4M = 3'h6;

  // ----------------------------------------------------------------------
  // Precompensation codes, in ns.
  // ----------------------------------------------------------------------
  localparam logic [7:0] FHC_PRECOMP_83 = 8'h53;
  localparam logic [7:0] FHC_PRECOMP_125 = 8'h7D;
  localparam logic [7:0] FHC_PRECOMP_208 = 8'hD0;
  localparam logic [7:0] FHC_PRECOMP_250 = 8'hFA;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int FHC_CLK_MHZ = 40;
  localparam int FHC_IDLE_MS = 500;
  localparam int FHC_IDLE_CYCLES = FHC_IDLE_MS * 1000 * FHC_CLK_MHZ;
  localparam int FHC_WAKE_US = 2000;
  localparam int FHC_WAKE_CYCLES = FHC_WAKE_US * FHC_CLK_MHZ;

  typedef struct packed {
    logic       fast_filter;
    logic       slow_filter;
    logic       speed_high;
    logic [2:0] divisor;
    logic [7:0] precomp_ns;
  } fhc_rate_cfg_t;

  typedef struct packed {
    logic       req_master;
    logic       dir_to_host;
    logic       non_dma_exec;
    logic       busy;
    logic [3:0] seeking;
  } fhc_status_t;

endpackage

// ===== hdl/fhc_rate_decode.sv
`timescale 1ns/1ps
module fhc_rate_decode
  import fhc_pkg::*;
(
  // Selection.
  input wire logic [1:0] rate_in,
  input wire logic drive_type_in,
  input wire logic precomp_select_in,
  // Decoded configuration.
  output fhc_rate_cfg_t cfg_out
);

  always_comb begin
    cfg_out = '0;
    case (rate_in)
      FHC_RATE_500K: begin
        cfg_out.fast_filter = 1'b1;
        cfg_out.speed_high = 1'b1;
        cfg_out.divisor = FHC_DIV_8M;
        cfg_out.precomp_ns = FHC_PRECOMP_125;
      end
      FHC_RATE_300K: begin
        cfg_out.slow_filter = 1'b1;
        if (drive_type_in) begin
          cfg_out.divisor = FHC_DIV_4M8;
          cfg_out.precomp_ns = FHC_PRECOMP_208;
        end else begin
          cfg_out.divisor = FHC_DIV_4M; // [R2]
          cfg_out.precomp_ns = precomp_select_in ? FHC_PRECOMP_250 : FHC_PRECOMP_125; // [R4]
        end
      end
      FHC_RATE_250K: begin
        cfg_out.slow_filter = 1'b1;
        cfg_out.divisor = FHC_DIV_4M;
        cfg_out.precomp_ns = precomp_select_in ? FHC_PRECOMP_250 : FHC_PRECOMP_125; // [R4]
      end
      default: begin
        cfg_out.speed_high = ~drive_type_in; // [R3]
        cfg_out.divisor = FHC_DIV_8M;
        cfg_out.precomp_ns = FHC_PRECOMP_83;
      end
    endcase
  end

endmodule

// ===== tb/fhc_core_model.sv
`timescale 1ns/1ps
module fhc_core_model
  import fhc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Transfers from the register block.
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic hold_in,
  input wire logic run_in,
  // Handshake back to the register block.
  output logic [7:0] rdata_out,
  output fhc_status_t st_out,
  output logic irq_out
);
  // --------------------------------------------------------------
  // Two-byte seek-like command with a one-byte result phase.
  // --------------------------------------------------------------
  fhc_status_t st_q, st_d;
  logic [1:0] gap_q, gap_d, drv_q, drv_d;
  logic cnt_q, cnt_d;
  always_comb begin
    st_d = st_q;
    gap_d = gap_q;
    cnt_d = cnt_q;
    drv_d = drv_q;
    if (gap_q != 2'h0) begin
      gap_d = gap_q - 2'h1;
      st_d.req_master = (gap_q == 2'h1);
    end
    if (wr_in) begin
      st_d.req_master = 1'b0;
      gap_d = 2'h2;
      st_d.busy = 1'b1;
      cnt_d = 1'b1;
      if (cnt_q) begin
        drv_d = wdata_in[1:0];
        st_d.seeking[wdata_in[1:0]] = 1'b1;
        st_d.dir_to_host = 1'b1;
      end
    end
    if (rd_in) begin
      st_d = '0;
      gap_d = 2'h2;
      cnt_d = 1'b0;
    end
    // The model only leaves reset once the soft reset bit lets it go.
    if (hold_in) begin
      st_d = '0;
      gap_d = 2'h2;
      cnt_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
      gap_q <= 2'h2;
      cnt_q <= 1'b0;
      drv_q <= 2'h0;
    end else if (run_in) begin
      st_q <= st_d;
      gap_q <= gap_d;
      cnt_q <= cnt_d;
      drv_q <= drv_d;
    end
  end
  assign rdata_out = {6'h08, drv_q};
  assign st_out = st_q;
  assign irq_out = st_q.dir_to_host;
endmodule

// ===== tb/floppy_host_control_registers_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module floppy_host_control_registers_bench;
  import fhc_pkg::*;
  // --------------------------------------------------------------
  // Signals.
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rate;
    logic dt;
    logic [2:0] div;
    logic [7:0] pc0;
    logic [7:0] pc1;
    logic [1:0] flt;
    logic spd;
  } fhc_row_t;
  fhc_row_t rows[8] = '{'{2'h0, 1'b0, 3'h3, 8'h7D, 8'h7D, 2'h2, 1'b1},
    '{2'h0, 1'b1, 3'h3, 8'h7D, 8'h7D, 2'h2, 1'b1}, '{2'h1, 1'b0, 3'h6, 8'h7D, 8'hFA, 2'h1, 1'b0},
    '{2'h1, 1'b1, 3'h5, 8'hD0, 8'hD0, 2'h1, 1'b0}, '{2'h2, 1'b0, 3'h6, 8'h7D, 8'hFA, 2'h1, 1'b0},
    '{2'h2, 1'b1, 3'h6, 8'h7D, 8'hFA, 2'h1, 1'b0}, '{2'h3, 1'b0, 3'h3, 8'h53, 8'h53, 2'h0, 1'b1},
    '{2'h3, 1'b1, 3'h3, 8'h53, 8'h53, 2'h0, 1'b0}};
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, rd = 1'b0, wr = 1'b0, dt = 1'b0, ps = 1'b0;
  logic dchg_n = 1'b1, ack_n = 1'b1, idle = 1'b0, pdc = 1'b0, apd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, q, oe_q, cwd_q, rdata, rdoe, cwd, mrd, pc;
  logic cwr_q, crd_q, cwr, crd, cack, creset, cen, osc, ffast, fslow, spd, tick;
  logic irq, irq_oe, dreq, dreq_oe, mirq;
  logic [3:0] mot_n, sel_n;
  logic [2:0] div;
  fhc_status_t mst;
  int err_total = 0, tests_run = 0, n, i, p, d;
  fhc_host_regs #(.IDLE_CYCLES(20), .WAKE_CYCLES(8)) DUT (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata),
    .rdata_out(rdata), .rdata_oe_out(rdoe), .core_rdata_in(mrd), .core_req_in(mst.req_master),
    .core_dir_in(mst.dir_to_host), .core_non_dma_in(mst.non_dma_exec), .core_busy_in(mst.busy),
    .core_seeking_in(mst.seeking), .core_irq_in(mirq), .core_dreq_in(mirq), .core_idle_in(idle),
    .power_down_cmd_in(pdc), .auto_power_down_in(apd), .core_wdata_out(cwd), .core_wr_out(cwr),
    .core_rd_out(crd), .core_dma_ack_out(cack), .core_reset_out(creset), .core_clk_en_out(cen),
    .osc_run_out(osc), .drive_type_input_in(dt), .precomp_select_input_in(ps),
    .disk_changed_n_in(dchg_n), .dma_acknowledge_n_in(ack_n), .motor_on_n_out(mot_n),
    .unit_select_n_out(sel_n), .filter_ground_fast_out(ffast), .filter_ground_slow_out(fslow),
    .spindle_speed_low_current_out(spd), .precomp_ns_out(pc), .prescale_div_out(div),
    .master_clk_tick_out(tick), .irq_out(irq), .irq_oe_out(irq_oe), .dma_request_out(dreq),
    .dma_request_oe_out(dreq_oe));
  fhc_core_model u_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wdata_in(cwd),
    .wr_in(cwr), .rd_in(crd), .hold_in(creset), .run_in(cen), .rdata_out(mrd), .st_out(mst),
    .irq_out(mirq));
  // --------------------------------------------------------------
  // Bus cycles and helpers.
  // --------------------------------------------------------------
  // Called on a rising edge; the trailing idle edge lets a write land before any check.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] dat);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= dat;
    @(posedge clk_sys_in);
    q = rdata;
    oe_q = rdoe;
    cwd_q = cwd;
    cwr_q = cwr;
    crd_q = crd;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // The host polls status before every byte, as a real driver must.
  task automatic poll();
    int k;
    for (k = 0; k < 30; k++) begin
      acc(1'b0, 3'h4, 8'h00);
      if (q[7] === 1'b1) break;
    end
  endtask
  task automatic wosc(input logic v);
    int k;
    for (k = 0; k < 40 && osc !== v; k++) @(posedge clk_sys_in);
  endtask
  task automatic gap();
    int k;
    for (k = 0; k < 20 && tick !== 1'b1; k++) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    n = 1;
    while (tick !== 1'b1 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
  endtask
  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_total++;
    summarize();
  end
  // --------------------------------------------------------------
  // Tests.
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    `CHK(mot_n, 4'hF)
    `CHK(sel_n, 4'hF)
    `CHK(creset, 1'b1)
    `CHK({irq_oe, dreq_oe}, 2'h0)
    `CHK({div, pc, fslow}, {3'h6, 8'h7D, 1'b1})
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      for (p = 0; p < 2; p++) begin
        dt <= rows[i].dt;
        ps <= p[0];
        acc(1'b1, 3'h7, {6'h00, rows[i].rate});
        `CHK(pc, p ? rows[i].pc1 : rows[i].pc0)
        `CHK({ffast, fslow, spd}, {rows[i].flt, rows[i].spd})
        `CHK(div, rows[i].div)
        gap();
        gap();
        `CHK(n, int'(rows[i].div))
      end
    end
    $display("test rate table done");
    acc(1'b1, 3'h7, 8'h02);
    acc(1'b1, 3'h2, 8'h1C);
    `CHK({mot_n, sel_n, creset, irq_oe, dreq_oe}, {8'hEE, 3'h3})
    for (i = 0; i < 8; i++) begin
      if (i != 2 && i != 4 && i != 5 && i != 7) begin
        acc(1'b1, i[2:0], 8'hF0);
        acc(1'b0, i[2:0], 8'h00);
        `CHK(oe_q, 8'h00)
      end
    end
    acc(1'b0, 3'h2, 8'h00);
    `CHK(oe_q, 8'h00)
    `CHK({mot_n, div}, {4'hE, 3'h6})
    dchg_n <= 1'b0;
    @(posedge clk_sys_in);
    acc(1'b0, 3'h7, 8'h00);
    `CHK({oe_q, q[7]}, {8'h80, 1'b1})
    dchg_n <= 1'b1;
    acc(1'b0, 3'h7, 8'h00);
    acc(1'b0, 3'h7, 8'h00);
    `CHK(q[7], 1'b0)
    $display("test decode done");
    for (d = 0; d < 4; d++) begin
      acc(1'b1, 3'h2, 8'h0C | d[7:0] | (8'h10 << d));
      `CHK({mot_n, sel_n}, ~{4'h1 << d, 4'h1 << d})
      acc(1'b1, 3'h2, 8'h0C | d[7:0] | (8'h10 << ((d + 1) % 4)));
      `CHK(sel_n, 4'hF)
    end
    acc(1'b1, 3'h2, 8'h14);
    ack_n <= 1'b0;
    @(posedge clk_sys_in);
    `CHK({irq_oe, dreq_oe, cack}, 3'h0)
    acc(1'b1, 3'h2, 8'h1C);
    `CHK(cack, 1'b1)
    ack_n <= 1'b1;
    acc(1'b1, 3'h7, 8'h00);
    acc(1'b1, 3'h2, 8'h18);
    `CHK({creset, div, mot_n}, {1'b1, 3'h3, 4'hE})
    acc(1'b1, 3'h2, 8'h1C);
    $display("test drive control done");
    poll();
    `CHK(q, 8'h80)
    acc(1'b1, 3'h5, 8'h0F);
    `CHK({cwr_q, cwd_q}, {1'b1, 8'h0F})
    acc(1'b0, 3'h4, 8'h00);
    `CHK({q[7], q[4]}, 2'h1)
    poll();
    acc(1'b1, 3'h5, 8'h02);
    poll();
    `CHK(q, 8'hD4)
    `CHK({irq, irq_oe, dreq, dreq_oe}, 4'hF)
    acc(1'b0, 3'h5, 8'h00);
    `CHK(q, 8'h22)
    `CHK(crd_q, 1'b1)
    poll();
    `CHK(q, 8'h80)
    $display("test command flow done");
    idle <= 1'b1;
    pdc <= 1'b1;
    @(posedge clk_sys_in);
    pdc <= 1'b0;
    wosc(1'b0);
    `CHK({osc, cen}, 2'h0)
    `CHK({mot_n, sel_n}, 8'hEE)
    idle <= 1'b0;
    acc(1'b1, 3'h5, 8'hAA);
    `CHK(cwr_q, 1'b0)
    wosc(1'b1);
    `CHK(osc, 1'b1)
    acc(1'b0, 3'h4, 8'h00);
    `CHK(q[7], 1'b0)
    poll();
    `CHK(q[7], 1'b1)
    apd <= 1'b1;
    idle <= 1'b1;
    repeat (15) @(posedge clk_sys_in);
    `CHK(osc, 1'b1)
    wosc(1'b0);
    `CHK(osc, 1'b0)
    apd <= 1'b0;
    idle <= 1'b0;
    acc(1'b0, 3'h4, 8'h00);
    wosc(1'b1);
    `CHK(osc, 1'b1)
    $display("test low power done");
    rst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    `CHK({mot_n, sel_n, creset, div}, {8'hFF, 1'b1, 3'h6})
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    `CHK({mot_n, osc, irq_oe}, {4'hF, 1'b1, 1'b0})
    $display("test second reset done");
    summarize();
  end
endmodule
